// [include/tdcu_pkg.sv]
// Package with opcodes, codes, layouts and types of the tape diagnostic command unit.
package tdcu_pkg;
  localparam logic [7:0] OPC_DIAG_REQ     = 8'h1d;
  localparam logic [7:0] OPC_BUF_WRITE    = 8'h3b;
  localparam logic [7:0] ERR_NONE         = 8'h00;
  localparam logic [7:0] ERR_RAM_DATA     = 8'h80;
  localparam logic [7:0] ERR_FILE_MARK    = 8'h81;
  localparam logic [7:0] ERR_ERASE        = 8'h82;
  localparam logic [7:0] ERR_REWIND       = 8'h83;
  localparam logic [7:0] ERR_BLANK        = 8'h84;
  localparam logic [7:0] ERR_BLOCK_LEN    = 8'h85;
  localparam logic [7:0] ERR_DATA         = 8'h86;
  localparam logic [7:0] ERR_PARITY       = 8'h87;
  localparam logic [7:0] ERR_REV_READ     = 8'h88;
  localparam logic [7:0] ERR_ABNORMAL     = 8'h89;
  localparam int         SELF_TEST_BIT    = 2;
  localparam int         UNIT_TEST_BIT    = 0;
  localparam int         CDB_BYTES        = 10;
  localparam int         PARAM_BYTES      = 9;
  localparam int         RESULT_BYTES     = 9;
  localparam int         NUM_TESTS        = 5;
  localparam logic [2:0] RAM_TEST_NUM     = 3'h0;
  localparam logic [1:0] MODE_MASK_BITS   = 2'h3;
  localparam logic [3:0] RESULT_BYTES_4   = 4'h9;
  localparam logic [7:0] PASS_NONE        = 8'h00;

  typedef enum logic [1:0] {
    TDCU_ST_GOOD,
    TDCU_ST_CHECK
  } tdcu_status_t;

  typedef enum logic [1:0] {
    TDCU_SK_NONE,
    TDCU_SK_HARDWARE
  } tdcu_sense_t;

  // Drive state as it stands in the two status bytes, bit 7 first.
  typedef struct packed {
    logic formatter_busy;
    logic data_busy;
    logic check_char_gate;
    logic end_of_tape_marker;
    logic ready;
    logic rewinding;
    logic file_protect;
    logic online;
    logic parity_error;
    logic file_mark;
    logic buffer_overflow;
    logic high_speed;
    logic nrzi_density;
    logic beginning_of_tape_marker;
    logic formatter_busy_interrupt;
    logic data_busy_interrupt;
  } tdcu_drive_status_t;

  typedef struct packed {
    logic [7:0]  error_code;
    logic [7:0]  test_number;
    logic [23:0] info;
    logic [7:0]  expected;
    logic [7:0]  actual;
    logic [15:0] drive_status;
  } tdcu_result_t;

  // Outcome reported by an exerciser step or the RAM test.
  typedef struct packed {
    logic        fail;
    logic [7:0]  error_code;
    logic [23:0] info;
    logic [7:0]  expected;
    logic [7:0]  actual;
  } tdcu_outcome_t;

  typedef struct packed {
    logic [7:0]  t5_start;
    logic [7:0]  t5_incr;
    logic [15:0] t5_block_len;
  } tdcu_t5_cfg_t;

  typedef struct packed {
    logic [1:0]  mode;
    logic [7:0]  buffer_id;
    logic [23:0] offset;
    logic [23:0] length;
    logic        flag;
    logic        link;
  } tdcu_buf_write_t;
endpackage : tdcu_pkg

// [rtl/tdcu_cdb_decode.sv]
// Combinational decoder for the diagnostic request and buffer-write command blocks.
`timescale 1ns/1ps
module tdcu_cdb_decode
  import tdcu_pkg::*;
(
  input  wire logic [8*tdcu_pkg::CDB_BYTES-1:0] cdb_i,
  output logic                                  is_diag_o,
  output logic                                  is_buf_write_o,
  output logic                                  self_test_select_o,
  output logic                                  unit_test_select_o,
  output logic [15:0]                           param_len_o,
  output tdcu_pkg::tdcu_buf_write_t             buf_write_o
);
  logic [7:0] b [tdcu_pkg::CDB_BYTES];

  for (genvar i = 0; i < CDB_BYTES; i++) begin : g_bytes
    assign b[i] = cdb_i[8*i +: 8];
  end

  always_comb begin
    is_diag_o          = (b[0] == OPC_DIAG_REQ);
    is_buf_write_o     = (b[0] == OPC_BUF_WRITE);
    self_test_select_o = b[1][SELF_TEST_BIT];
    unit_test_select_o = b[1][UNIT_TEST_BIT];
    param_len_o        = {b[3], b[4]};
    buf_write_o.mode      = b[1][1:0] & MODE_MASK_BITS;
    buf_write_o.buffer_id = b[2];
    buf_write_o.offset    = {b[3], b[4], b[5]};
    buf_write_o.length    = {b[6], b[7], b[8]};
    buf_write_o.flag      = b[9][1];
    buf_write_o.link      = b[9][0];
  end
endmodule : tdcu_cdb_decode

// [rtl/tdcu_param_capture.sv]
// Collects the parameter list bytes of a unit test request.
`timescale 1ns/1ps
module tdcu_param_capture
  import tdcu_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   clear_i,
  input  wire logic                   byte_valid_i,
  input  wire logic [7:0]             byte_i,
  output logic [8*tdcu_pkg::NUM_TESTS-1:0] pass_counts_o,
  output tdcu_pkg::tdcu_t5_cfg_t      t5_cfg_o
);
  logic [7:0] list [PARAM_BYTES];
  logic [7:0] next_list [PARAM_BYTES];
  logic [3:0] idx;
  logic [3:0] next_idx;

  always_comb begin
    next_list = list;
    next_idx  = idx;
    if (clear_i) begin
      next_idx = 4'h0;
    end else if (byte_valid_i && (idx < RESULT_BYTES_4)) begin
      next_list[idx] = byte_i;
      next_idx       = idx + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idx <= 4'h0;
      for (int i = 0; i < PARAM_BYTES; i++) list[i] <= 8'h00;
    end else begin
      idx  <= next_idx;
      list <= next_list;
    end
  end

  for (genvar t = 0; t < NUM_TESTS; t++) begin : g_pass
    assign pass_counts_o[8*t +: 8] = list[t];
  end
  assign t5_cfg_o.t5_block_len = {list[5], list[6]};
  assign t5_cfg_o.t5_start     = list[7];
  assign t5_cfg_o.t5_incr      = list[8];
endmodule : tdcu_param_capture

// [rtl/tdcu_diag_unit.sv]
// Diagnostic command sequencer with result record for the tape controller target.
`timescale 1ns/1ps
module tdcu_diag_unit
  import tdcu_pkg::*;
(
  input  wire logic                             sys_clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             cdb_valid_i,
  input  wire logic [8*tdcu_pkg::CDB_BYTES-1:0] cdb_i,
  output logic                                  param_req_o,
  output logic [15:0]                           param_len_o,
  input  wire logic                             param_valid_i,
  input  wire logic [7:0]                       param_byte_i,
  input  wire logic                             param_done_i,
  output logic                                  ram_test_start_o,
  input  wire logic                             ram_test_done_i,
  input  wire tdcu_pkg::tdcu_outcome_t          ram_test_outcome_i,
  output logic                                  tape_test_start_o,
  output logic [2:0]                            tape_test_num_o,
  output tdcu_pkg::tdcu_t5_cfg_t                t5_cfg_o,
  input  wire logic                             tape_test_done_i,
  input  wire tdcu_pkg::tdcu_outcome_t          tape_test_outcome_i,
  input  wire tdcu_pkg::tdcu_drive_status_t     drive_status_i,
  output logic                                  cmd_done_o,
  output tdcu_pkg::tdcu_status_t                cmd_status_o,
  output tdcu_pkg::tdcu_sense_t                 sense_key_o,
  output logic                                  buf_write_valid_o,
  output tdcu_pkg::tdcu_buf_write_t             buf_write_o,
  input  wire logic                             result_rd_i,
  input  wire logic [15:0]                      result_alloc_i,
  output logic                                  result_valid_o,
  output logic [7:0]                            result_byte_o,
  output logic                                  result_last_o
);
  import tdcu_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_FETCH,
    S_RAM,
    S_NEXT,
    S_TAPE,
    S_PASS,
    S_DONE
  } tdcu_state_t;

  tdcu_state_t          state;
  tdcu_state_t          next_state;
  logic                 is_diag;
  logic                 is_bw;
  logic                 st_sel;
  logic                 ut_sel;
  logic [15:0]          plen;
  tdcu_buf_write_t      bw_dec;
  logic [8*NUM_TESTS-1:0] pass_counts;
  tdcu_t5_cfg_t         t5_cfg;
  logic [2:0]           test_num;
  logic [2:0]           next_test_num;
  logic [7:0]           passes_left;
  logic [7:0]           next_passes_left;
  tdcu_result_t         result;
  tdcu_result_t         next_result;
  tdcu_status_t         status;
  tdcu_status_t         next_status;
  tdcu_sense_t          sense;
  tdcu_sense_t          next_sense;
  logic                 done;
  logic                 next_done;
  logic                 bw_valid;
  logic                 next_bw_valid;
  tdcu_buf_write_t      bw_reg;
  tdcu_buf_write_t      next_bw_reg;
  logic [3:0]           rd_idx;
  logic [3:0]           next_rd_idx;
  logic [3:0]           rd_limit;
  logic [3:0]           next_rd_limit;
  logic                 rd_active;
  logic                 next_rd_active;
  logic [7:0]           rd_byte;
  logic [7:0]           next_rd_byte;
  logic                 rd_last;
  logic                 next_rd_last;
  logic                 rd_valid;
  logic                 next_rd_valid;
  logic [7:0]           rec [RESULT_BYTES];
  logic                 accept;

  tdcu_cdb_decode u_decode (
    .cdb_i              (cdb_i),
    .is_diag_o          (is_diag),
    .is_buf_write_o     (is_bw),
    .self_test_select_o (st_sel),
    .unit_test_select_o (ut_sel),
    .param_len_o        (plen),
    .buf_write_o        (bw_dec)
  );

  // Only a fresh request in idle starts a fetch, so stray bytes never land in the list.
  tdcu_param_capture u_params (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .clear_i       (accept),
    .byte_valid_i  (param_valid_i && (state == S_FETCH)),
    .byte_i        (param_byte_i),
    .pass_counts_o (pass_counts),
    .t5_cfg_o      (t5_cfg)
  );

  assign accept = cdb_valid_i && is_diag && (state == S_IDLE);

  // Tape tests 1 to 5 cover motion, 8K blocks, growing blocks, buffer and patterns.
  function automatic logic [7:0] pass_of(input logic [2:0] n);
    pass_of = pass_counts[8*(n - 3'h1) +: 8];
  endfunction : pass_of

  always_comb begin
    next_state       = state;
    next_test_num    = test_num;
    next_passes_left = passes_left;
    next_result      = result;
    next_status      = status;
    next_sense       = sense;
    next_done        = 1'b0;
    next_bw_valid    = 1'b0;
    next_bw_reg      = bw_reg;
    if (cdb_valid_i && is_bw) begin
      next_bw_valid = 1'b1;
      next_bw_reg   = bw_dec;
    end
    unique case (state)
      S_IDLE: begin
        if (accept) begin
          // The old record survives any other command.
          next_result = '0;
          next_status = TDCU_ST_GOOD;
          next_sense  = TDCU_SK_NONE;
          if (st_sel) begin
            next_state = S_RAM;
          end else if (ut_sel) begin
            next_state = S_FETCH;
          end else begin
            next_state = S_DONE;
          end
        end
      end
      S_FETCH: begin
        if (param_done_i) begin
          next_test_num = 3'h1;
          next_state    = S_NEXT;
        end
      end
      S_RAM: begin
        if (ram_test_done_i) begin
          next_state = S_DONE;
          next_result.drive_status = drive_status_i;
          if (ram_test_outcome_i.fail) begin
            next_result.error_code  = ram_test_outcome_i.error_code;
            next_result.test_number = {5'h00, RAM_TEST_NUM};
            next_result.info        = ram_test_outcome_i.info;
            next_result.expected    = ram_test_outcome_i.expected;
            next_result.actual      = ram_test_outcome_i.actual;
            next_status             = TDCU_ST_CHECK;
            next_sense              = TDCU_SK_HARDWARE;
          end
        end
      end
      S_NEXT: begin
        if (test_num > 3'(NUM_TESTS)) begin
          next_state = S_DONE;
        end else if (pass_of(test_num) == PASS_NONE) begin
          next_test_num = test_num + 3'h1;
        end else begin
          next_passes_left = pass_of(test_num);
          next_state       = S_TAPE;
        end
      end
      S_TAPE: begin
        next_state = S_PASS;
      end
      S_PASS: begin
        if (tape_test_done_i) begin
          next_result.drive_status = drive_status_i;
          if (tape_test_outcome_i.fail) begin
            next_result.error_code  = tape_test_outcome_i.error_code;
            next_result.test_number = {5'h00, test_num};
            next_result.info        = tape_test_outcome_i.info;
            next_result.expected    = tape_test_outcome_i.expected;
            next_result.actual      = tape_test_outcome_i.actual;
            next_status             = TDCU_ST_CHECK;
            next_state              = S_DONE;
          end else if (passes_left == 8'h01) begin
            next_test_num = test_num + 3'h1;
            next_state    = S_NEXT;
          end else begin
            next_passes_left = passes_left - 8'h01;
            next_state       = S_TAPE;
          end
        end
      end
      S_DONE: begin
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state       <= S_IDLE;
      test_num    <= 3'h0;
      passes_left <= 8'h00;
      result      <= '0;
      status      <= TDCU_ST_GOOD;
      sense       <= TDCU_SK_NONE;
      done        <= 1'b0;
      bw_valid    <= 1'b0;
      bw_reg      <= '0;
    end else begin
      state       <= next_state;
      test_num    <= next_test_num;
      passes_left <= next_passes_left;
      result      <= next_result;
      status      <= next_status;
      sense       <= next_sense;
      done        <= next_done;
      bw_valid    <= next_bw_valid;
      bw_reg      <= next_bw_reg;
    end
  end

  assign rec[0] = result.error_code;
  assign rec[1] = result.test_number;
  assign rec[2] = result.info[23:16];
  assign rec[3] = result.info[15:8];
  assign rec[4] = result.info[7:0];
  assign rec[5] = result.expected;
  assign rec[6] = result.actual;
  assign rec[7] = result.drive_status[15:8];
  assign rec[8] = result.drive_status[7:0];

  // Result readout: one byte per cycle, clipped to nine bytes.
  always_comb begin
    next_rd_idx    = rd_idx;
    next_rd_limit  = rd_limit;
    next_rd_active = rd_active;
    next_rd_valid  = 1'b0;
    next_rd_byte   = rd_byte;
    next_rd_last   = 1'b0;
    if (!rd_active) begin
      if (result_rd_i && (result_alloc_i != 16'h0000)) begin
        next_rd_active = 1'b1;
        next_rd_idx    = 4'h0;
        next_rd_limit  = (result_alloc_i > 16'(RESULT_BYTES)) ?
                         RESULT_BYTES_4 : result_alloc_i[3:0];
      end
    end else begin
      next_rd_valid = 1'b1;
      next_rd_byte  = rec[rd_idx];
      next_rd_last  = (rd_idx == rd_limit - 4'h1);
      next_rd_idx   = rd_idx + 4'h1;
      if (next_rd_last) begin
        next_rd_active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_idx    <= 4'h0;
      rd_limit  <= 4'h0;
      rd_active <= 1'b0;
      rd_valid  <= 1'b0;
      rd_byte   <= 8'h00;
      rd_last   <= 1'b0;
    end else begin
      rd_idx    <= next_rd_idx;
      rd_limit  <= next_rd_limit;
      rd_active <= next_rd_active;
      rd_valid  <= next_rd_valid;
      rd_byte   <= next_rd_byte;
      rd_last   <= next_rd_last;
    end
  end

  assign param_req_o       = (state == S_FETCH);
  assign param_len_o       = plen;
  assign ram_test_start_o  = (state == S_RAM);
  assign tape_test_start_o = (state == S_TAPE);
  assign tape_test_num_o   = test_num;
  assign t5_cfg_o          = t5_cfg;
  assign cmd_done_o        = done;
  assign cmd_status_o      = status;
  assign sense_key_o       = sense;
  assign buf_write_valid_o = bw_valid;
  assign buf_write_o       = bw_reg;
  assign result_valid_o    = rd_valid;
  assign result_byte_o     = rd_byte;
  assign result_last_o     = rd_last;
endmodule : tdcu_diag_unit

// [verification/tdcu_diag_unit_sva.sv]
// Checker on the ports of the diagnostic command unit.
`timescale 1ns/1ps
module tdcu_diag_unit_sva (
  input wire logic                             sys_clk_i,
  input wire logic                             rst_i,
  input wire logic                             cdb_valid_i,
  input wire logic [8*tdcu_pkg::CDB_BYTES-1:0] cdb_i,
  input wire logic                             param_req_o,
  input wire logic                             ram_test_start_o,
  input wire logic                             ram_test_done_i,
  input wire tdcu_pkg::tdcu_outcome_t          ram_test_outcome_i,
  input wire logic                             tape_test_start_o,
  input wire logic [2:0]                       tape_test_num_o,
  input wire logic                             tape_test_done_i,
  input wire tdcu_pkg::tdcu_outcome_t          tape_test_outcome_i,
  input wire logic                             cmd_done_o,
  input wire tdcu_pkg::tdcu_status_t           cmd_status_o,
  input wire tdcu_pkg::tdcu_sense_t            sense_key_o,
  input wire logic                             buf_write_valid_o,
  input wire tdcu_pkg::tdcu_buf_write_t        buf_write_o
);
  import tdcu_pkg::*;
  logic            is_diag;
  logic            busy;
  logic            next_busy;
  logic            free;
  tdcu_buf_write_t bw_exp;
  assign is_diag = cdb_valid_i && cdb_i[7:0] == OPC_DIAG_REQ;
  assign bw_exp  = {cdb_i[9:8], cdb_i[23:16], cdb_i[31:24], cdb_i[39:32], cdb_i[47:40],
                    cdb_i[55:48], cdb_i[63:56], cdb_i[71:64], cdb_i[73:72]};
  // A request met while busy is dropped, so the checker must know when the unit is free.
  // The unit is already idle in the cycle that shows the done pulse, so a request
  // arriving then is taken and keeps the unit busy.
  assign free = !busy || cmd_done_o;
  always_comb begin
    next_busy = free ? is_diag : 1'b1;
  end
  always_ff @(posedge sys_clk_i) begin
    busy <= rst_i ? 1'b0 : next_busy;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  ram_only_a: assert property ($rose(ram_test_start_o) |->
    $past(is_diag) && $past(cdb_i[10]) && $past(free)) else $error("RAM test without request.");
  no_motion_a: assert property (ram_test_start_o |-> !tape_test_start_o && !param_req_o)
    else $error("Tape motion or fetch during RAM test.");
  list_fetch_a: assert property ($rose(param_req_o) |->
    $past(is_diag) && !$past(cdb_i[10]) && $past(cdb_i[8])) else $error("Unexpected fetch.");
  idle_good_a: assert property (is_diag && free && !cdb_i[10] && !cdb_i[8] |->
    ##2 cmd_done_o && cmd_status_o == TDCU_ST_GOOD) else $error("No-test request mishandled.");
  ram_fail_a: assert property (ram_test_start_o && ram_test_done_i && ram_test_outcome_i.fail
    |-> ##2 cmd_done_o && cmd_status_o == TDCU_ST_CHECK && sense_key_o == TDCU_SK_HARDWARE)
    else $error("RAM failure not reported as hardware error.");
  tape_abort_a: assert property (tape_test_done_i && tape_test_outcome_i.fail |->
    (!tape_test_start_o [*3]) and (##2 cmd_done_o && cmd_status_o == TDCU_ST_CHECK))
    else $error("Tests not abandoned after a failure.");
  tape_num_a: assert property (tape_test_start_o |-> tape_test_num_o inside {[3'h1:3'h5]})
    else $error("Tape test number out of range.");
  buf_fields_a: assert property (cdb_valid_i && cdb_i[7:0] == OPC_BUF_WRITE |=>
    buf_write_valid_o && buf_write_o == $past(bw_exp)) else $error("Buffer write misdecoded.");
endmodule : tdcu_diag_unit_sva
bind tdcu_diag_unit tdcu_diag_unit_sva chk (.*);

// [verification/tdcu_exerciser_model.sv]
// Behavioural RAM tester and tape exerciser that answer the diagnostic sequencer.
`timescale 1ns/1ps
module tdcu_exerciser_model (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    slow_i,
  input  wire logic                    fail_ram_i,
  input  wire logic [2:0]              fail_num_i,
  input  wire tdcu_pkg::tdcu_outcome_t fault_i,
  input  wire logic                    ram_start_i,
  input  wire logic                    tape_start_i,
  input  wire logic [2:0]              tape_num_i,
  output tdcu_pkg::tdcu_outcome_t      outcome_o,
  output logic                         ram_done_o,
  output logic                         tape_done_o
);
  import tdcu_pkg::*;
  logic [3:0]    cnt;
  logic [3:0]    next_cnt;
  logic          seen;
  logic          next_seen;
  logic          tape_run;
  logic          next_tape_run;
  logic [2:0]    num;
  logic [2:0]    next_num;
  logic          ram_go;
  logic          fire;
  tdcu_outcome_t next_outcome;
  // Outside the done cycle the outcome shows the inverse of its last value, so a
  // sequencer that samples it late reads garbage instead of a lucky match.
  always_comb begin
    ram_go        = ram_start_i && !seen && !tape_run;
    fire          = (ram_go || tape_run) && cnt == (slow_i ? 4'h7 : 4'h1);
    next_cnt      = (fire || !(ram_go || tape_run)) ? 4'h0 : cnt + 4'h1;
    next_seen     = ram_start_i && (seen || fire);
    next_tape_run = tape_start_i || (tape_run && !fire);
    next_num      = tape_start_i ? tape_num_i : num;
    next_outcome  = ~outcome_o;
    if (fire) begin
      next_outcome      = fault_i;
      next_outcome.fail = tape_run ? num == fail_num_i : fail_ram_i;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      {cnt, seen, tape_run, num, outcome_o, ram_done_o, tape_done_o} <= '0;
    else
      {cnt, seen, tape_run, num, outcome_o, ram_done_o, tape_done_o} <=
        {next_cnt, next_seen, next_tape_run, next_num, next_outcome, fire && !tape_run,
         fire && tape_run};
  end
endmodule : tdcu_exerciser_model

// [verification/testbench.sv]
// Self-checking bench of the diagnostic command unit with its exerciser model.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import tdcu_pkg::*;
  typedef struct packed {
    logic [7:0]   sel;
    logic         ram_bad;
    tdcu_status_t st;
    tdcu_sense_t  sk;
    logic [55:0]  rec;
  } tdcu_row_t;
  localparam tdcu_outcome_t RAM_FAULT = {1'b0, ERR_RAM_DATA, 24'h012345, 8'h5a, 8'ha5};
  localparam tdcu_row_t ROWS [4] = '{
    '{8'h00, 1'b0, TDCU_ST_GOOD, TDCU_SK_NONE, 56'h0},
    '{8'h04, 1'b0, TDCU_ST_GOOD, TDCU_SK_NONE, 56'h0},
    '{8'h05, 1'b0, TDCU_ST_GOOD, TDCU_SK_NONE, 56'h0},
    '{8'h05, 1'b1, TDCU_ST_CHECK, TDCU_SK_HARDWARE, {ERR_RAM_DATA, 8'h00, 24'h012345, 16'h5aa5}}};
  logic                   sys_clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cdb_valid_i = 1'b0;
  logic [8*CDB_BYTES-1:0] cdb_i = '0;
  logic                   param_valid_i = 1'b0, param_done_i = 1'b0, result_rd_i = 1'b0;
  logic [7:0]             param_byte_i = 8'h00;
  logic [15:0]            result_alloc_i = 16'h0000;
  tdcu_drive_status_t     drive_status_i = 16'ha53c;
  logic                   slow = 1'b0, fail_ram = 1'b0;
  logic [2:0]             fail_num = 3'h0;
  tdcu_outcome_t          fault = '0;
  logic                   param_req_o, ram_test_start_o, ram_test_done_i, tape_test_start_o;
  logic                   tape_test_done_i, cmd_done_o, buf_write_valid_o;
  logic                   result_valid_o, result_last_o;
  logic [15:0]            param_len_o;
  logic [2:0]             tape_test_num_o;
  logic [7:0]             result_byte_o;
  tdcu_outcome_t          ram_test_outcome_i, tape_test_outcome_i;
  tdcu_t5_cfg_t           t5_cfg_o;
  tdcu_status_t           cmd_status_o;
  tdcu_sense_t            sense_key_o;
  tdcu_buf_write_t        buf_write_o;
  logic [11:0]            seq = '0;
  logic [71:0]            rec;
  int                     n_fail = 0, comparisons = 0;
  assign tape_test_outcome_i = ram_test_outcome_i;
  tdcu_diag_unit dut (.*);
  tdcu_exerciser_model model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow),
    .fail_ram_i(fail_ram), .fail_num_i(fail_num), .fault_i(fault),
    .ram_start_i(ram_test_start_o), .tape_start_i(tape_test_start_o),
    .tape_num_i(tape_test_num_o), .outcome_o(ram_test_outcome_i),
    .ram_done_o(ram_test_done_i), .tape_done_o(tape_test_done_i));
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (tape_test_start_o === 1'b1) seq <= {seq[8:0], tape_test_num_o};
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic run_diag(input logic [7:0] sel, input logic [71:0] plist, input logic poke);
    int k;
    cdb_i       = '0;
    cdb_i[39:0] = {8'h09, 8'h00, 8'h00, sel, OPC_DIAG_REQ};
    cdb_valid_i = 1'b1;
    tick();
    cdb_valid_i = 1'b0;
    if (sel[0] && !sel[2]) begin
      for (k = 0; k < 4 && param_req_o !== 1'b1; k++) tick();
      `CHK("fetch", {1'b1, 16'h0009}, {param_req_o, param_len_o})
      for (k = 0; k < PARAM_BYTES; k++) begin
        param_valid_i = 1'b1;
        param_byte_i  = plist[71-8*k -: 8];
        tick();
      end
      param_valid_i = 1'b0;
      param_done_i  = 1'b1;
      tick();
      param_done_i  = 1'b0;
    end
    // A second request while busy must vanish without disturbing the running tests.
    if (poke) begin
      cdb_i[15:8] = 8'h04;
      cdb_valid_i = 1'b1;
      tick();
      cdb_valid_i = 1'b0;
    end
    for (k = 0; k < 3000 && cmd_done_o !== 1'b1; k++) tick();
    if (cmd_done_o !== 1'b1) n_fail++;
  endtask : run_diag
  task automatic read_res(input logic [15:0] alloc);
    int k;
    int n;
    int last_n;
    int want;
    want           = (alloc > 16'h0009) ? 9 : int'(alloc);
    rec            = '0;
    n              = 0;
    last_n         = -1;
    result_alloc_i = alloc;
    result_rd_i    = 1'b1;
    tick();
    result_rd_i    = 1'b0;
    for (k = 0; k < 14; k++) begin
      if (result_valid_o === 1'b1) begin
        if (result_last_o === 1'b1) last_n = n;
        if (n < 9) rec[71-8*n -: 8] = result_byte_o;
        n++;
      end
      tick();
    end
    `CHK("byte count", {want, want - 1}, {n, last_n})
  endtask : read_res
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    n_fail++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    foreach (ROWS[i]) begin
      slow     = i[0];
      fail_ram = ROWS[i].ram_bad;
      fault    = ROWS[i].ram_bad ? RAM_FAULT : '0;
      run_diag(ROWS[i].sel, 72'h0, 1'b0);
      `CHK("status", {ROWS[i].st, ROWS[i].sk}, {cmd_status_o, sense_key_o})
      read_res(16'h0010);
      `CHK("record", ROWS[i].rec, rec[71:16])
      if (ROWS[i].sel != 8'h00) `CHK("drive bytes", drive_status_i, rec[15:0])
      $display("row %0d finished", i);
    end
    fail_ram = 1'b0;
    fault    = '0;
    seq      = '0;
    run_diag(8'h01, {8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 16'h0080, 8'hff, 8'h01}, 1'b0);
    `CHK("test order", {3'h1, 3'h3, 3'h3, 3'h5, TDCU_ST_GOOD}, {seq, cmd_status_o})
    `CHK("test five setup", {8'hff, 8'h01, 16'h0080}, t5_cfg_o)
    $display("unit sequence finished");
    fail_num = 3'h3;
    fault    = {1'b0, ERR_BLOCK_LEN, 24'h000010, 16'h0000};
    seq      = '0;
    run_diag(8'h01, {40'h0101010101, 32'h0}, 1'b1);
    `CHK("abort", {3'h0, 3'h1, 3'h2, 3'h3, TDCU_ST_CHECK}, {seq, cmd_status_o})
    read_res(16'h0004);
    `CHK("short record", {ERR_BLOCK_LEN, 8'h03, 16'h0000}, rec[71:40])
    cdb_i       = {8'h03, 24'h060504, 24'h030201, 8'h07, 8'h02, OPC_BUF_WRITE};
    cdb_valid_i = 1'b1;
    tick();
    cdb_valid_i = 1'b0;
    `CHK("buffer write", {1'b1, 2'h2, 8'h07, 48'h010203040506, 2'h3}, {buf_write_valid_o, buf_write_o})
    read_res(16'h0009);
    `CHK("held record", {ERR_BLOCK_LEN, 8'h03, 40'h0000100000, 16'ha53c}, rec)
    $display("abort and hold finished");
    test_done();
  end
endmodule : testbench
